// ==== include/eocb_consts.vh ====
// Constants for the Ethernet option configuration bank.
// Assumes inclusion by bare name from the design files.
`ifndef EOCB_CONSTS_VH
`define EOCB_CONSTS_VH
// ----------------------------------------------------------------
// Parameter numbers on the keypad parameter port
// ----------------------------------------------------------------
`define EOCB_P_VERSION    7'h06
`define EOCB_P_INDICATOR  7'h09
`define EOCB_P_IP_FIRST   7'h0A
`define EOCB_P_IP_LAST    7'h15
`define EOCB_P_SPEED      7'h16
`define EOCB_P_IN_FMT     7'h1D
`define EOCB_P_STAT_CNT   7'h1E
`define EOCB_P_STAT_FIRST 7'h1F
`define EOCB_P_STAT_LAST  7'h26
`define EOCB_P_OUT_FMT    7'h31
`define EOCB_P_CTRL_CNT   7'h32
`define EOCB_P_CTRL_FIRST 7'h33
`define EOCB_P_CTRL_LAST  7'h3A
`define EOCB_P_APPLY      7'h5E
// ----------------------------------------------------------------
// Value ranges and encodings
// ----------------------------------------------------------------
`define EOCB_SPEED_AUTO   2'h0
`define EOCB_SPEED_100    2'h1
`define EOCB_SPEED_10     2'h2
`define EOCB_SPEED_MAX    16'h0002
`define EOCB_OCTET_MAX    16'h00FF
`define EOCB_FMT_MAX      16'h000B
`define EOCB_FMT_CFG_MIN  4'h4
`define EOCB_FMT_CFG_BASE 4'h3
`define EOCB_APPLY_VAL    16'h0001
`define EOCB_IN_FIX_BASE  8'h46
`define EOCB_IN_FIX_ALT   8'h6E
`define EOCB_IN_CFG_BASE  8'h89
`define EOCB_OUT_FIX_BASE 8'h14
`define EOCB_OUT_FIX_ALT  8'h64
`define EOCB_OUT_CFG_BASE 8'h75
`define EOCB_FIX_BYTES    5'h04
`endif

// ==== logic/eocb_bank.v ====
// Configuration and status parameter bank of the Ethernet option module.
// Assumes a synchronous keypad parameter port and a one-cycle commit handshake to nonvolatile storage.
//
// What this block does
// R1: Modbus TCP mode shows link, speed, error, alive indicator bits.
// R2: EtherNet/IP mode shows module and network red/green indicator bits.
// R3: Address, mask and gateway held as octets, each 0 to 255.
// R4: Dotted fields map in order to consecutive octet parameters.
// R5: Speed setting 0 auto, 1 forces 100Mbps, 2 forces 10Mbps.
// R6: Auto speed links at the highest speed the network offers.
// R7: Input format 0..3 selects fixed instances 70,71,110,111, four bytes.
// R8: Input format 4..11 selects instances 141..148, two bytes per parameter.
// R9: Output format 0..3 selects fixed instances 20,21,100,101, four bytes.
// R10: Output format 4..11 selects instances 121..128, two bytes per parameter.
// R11: Configuring party must set input and output formats equal.
// R12: Format settings are presented only in EtherNet/IP mode.
// R13: Status count follows input format only when 4 or above at update.
// R14: Control count follows output format only when 4 or above at update.
// R15: Eight status address slots; count of them sent to client.
// R16: Eight control address slots; count of them written from commands.
// R17: Changed settings stay pending until update command written with 1.
// R18: Update command restarts Ethernet communication with new settings.
// R19: Update command commits settings to survive power loss.
// R20: Version parameter reports the installed module version automatically.
// R21: Parameter counts unused in Modbus TCP mode.
// R22: Protocol switch sampled only at power-on or update command.
// R23: Read-only writes and out-of-range values leave stored value unchanged.
`timescale 1ns/1ps
`include "eocb_consts.vh"
module eocb_bank #(
   parameter SLOTS = 8
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        par_wr,
   input  wire        par_rd,
   input  wire [6:0]  par_num,
   input  wire [15:0] par_wdata,
   output reg  [15:0] par_rdata,
   output reg         par_rvalid,
   output reg         par_present,
   input  wire [15:0] module_version_in,
   input  wire        protocol_switch,
   input  wire [3:0]  indicator_in,
   input  wire        phy_link_100,
   output reg         proto_eip,
   output reg  [31:0] act_ip_addr,
   output reg  [31:0] act_ip_mask,
   output reg  [31:0] act_ip_gateway,
   output reg  [1:0]  act_link_speed,
   output reg  [7:0]  act_in_instance,
   output reg  [4:0]  act_in_bytes,
   output reg  [7:0]  act_out_instance,
   output reg  [4:0]  act_out_bytes,
   output reg  [3:0]  act_status_count,
   output reg  [3:0]  act_control_count,
   output reg         comm_restart,
   output reg         nv_commit,
   output reg         speed_is_100
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [7:0]  octet_q [0:11];
   reg [1:0]  link_speed_select_q;
   reg [3:0]  input_format_select_q;
   reg [3:0]  output_format_select_q;
   reg [15:0] status_address_slots_q  [0:SLOTS-1];
   reg [15:0] control_address_slots_q [0:SLOTS-1];
   reg [3:0]  status_param_count_q;
   reg [3:0]  control_param_count_q;
   reg        apply_settings_cmd_q;
   reg        started_q;
   reg [15:0] module_version_q;
   reg [3:0]  indicator_state_q;
   integer    i;

   wire [3:0] in_cnt;
   wire [3:0] out_cnt;
   wire [7:0] in_inst;
   wire [7:0] out_inst;
   wire [4:0] in_bytes;
   wire [4:0] out_bytes;

   wire in_ip    = (par_num >= `EOCB_P_IP_FIRST) && (par_num <= `EOCB_P_IP_LAST);
   wire in_stat  = (par_num >= `EOCB_P_STAT_FIRST) && (par_num <= `EOCB_P_STAT_LAST);
   wire in_ctrl  = (par_num >= `EOCB_P_CTRL_FIRST) && (par_num <= `EOCB_P_CTRL_LAST);
   wire [6:0] ip_idx   = par_num - `EOCB_P_IP_FIRST;
   wire [6:0] stat_idx = par_num - `EOCB_P_STAT_FIRST;
   wire [6:0] ctrl_idx = par_num - `EOCB_P_CTRL_FIRST;
   wire is_fmt   = (par_num == `EOCB_P_IN_FMT) || (par_num == `EOCB_P_OUT_FMT);
   wire apply_go = par_wr && (par_num == `EOCB_P_APPLY) && (par_wdata == `EOCB_APPLY_VAL);

   // ----------------------------------------------------------------
   // Format decoders
   // ----------------------------------------------------------------
   eocb_fmt_decode #(
      .FIX_BASE (`EOCB_IN_FIX_BASE),
      .FIX_ALT  (`EOCB_IN_FIX_ALT),
      .CFG_BASE (`EOCB_IN_CFG_BASE)
   ) u_in_dec (
      .fmt          (input_format_select_q),
      .instance_num (in_inst),
      .data_bytes   (in_bytes),
      .param_num    (in_cnt)
   );

   eocb_fmt_decode #(
      .FIX_BASE (`EOCB_OUT_FIX_BASE),
      .FIX_ALT  (`EOCB_OUT_FIX_ALT),
      .CFG_BASE (`EOCB_OUT_CFG_BASE)
   ) u_out_dec (
      .fmt          (output_format_select_q),
      .instance_num (out_inst),
      .data_bytes   (out_bytes),
      .param_num    (out_cnt)
   );

   // ----------------------------------------------------------------
   // Pending settings, written from the keypad port
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 12; i = i + 1) begin
            octet_q[i] <= 8'h00;
         end
         for (i = 0; i < SLOTS; i = i + 1) begin
            status_address_slots_q[i]  <= 16'h0000;
            control_address_slots_q[i] <= 16'h0000;
         end
         link_speed_select_q    <= `EOCB_SPEED_AUTO;
         input_format_select_q  <= 4'h0;
         output_format_select_q <= 4'h0;
      end else if (par_wr) begin
         // Out-of-range values are dropped whole, not clipped
         if (in_ip && (par_wdata <= `EOCB_OCTET_MAX)) begin
            octet_q[ip_idx[3:0]] <= par_wdata[7:0]; // R3 R4 R23
         end
         if ((par_num == `EOCB_P_SPEED) && (par_wdata <= `EOCB_SPEED_MAX)) begin
            link_speed_select_q <= par_wdata[1:0]; // R5 R23
         end
         if ((par_num == `EOCB_P_IN_FMT) && proto_eip && (par_wdata <= `EOCB_FMT_MAX)) begin
            input_format_select_q <= par_wdata[3:0]; // R12 R23
         end
         if ((par_num == `EOCB_P_OUT_FMT) && proto_eip && (par_wdata <= `EOCB_FMT_MAX)) begin
            output_format_select_q <= par_wdata[3:0]; // R12 R23
         end
         if (in_stat) begin
            status_address_slots_q[stat_idx[2:0]] <= par_wdata; // R15
         end
         if (in_ctrl) begin
            control_address_slots_q[ctrl_idx[2:0]] <= par_wdata; // R16
         end
      end
   end

   // ----------------------------------------------------------------
   // Update command, protocol sampling and applied settings
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         started_q            <= 1'b0;
         apply_settings_cmd_q <= 1'b0;
         proto_eip            <= 1'b0;
         status_param_count_q <= 4'h0;
         control_param_count_q <= 4'h0;
         act_ip_addr          <= 32'h00000000;
         act_ip_mask          <= 32'h00000000;
         act_ip_gateway       <= 32'h00000000;
         act_link_speed       <= `EOCB_SPEED_AUTO;
         act_in_instance      <= `EOCB_IN_FIX_BASE;
         act_in_bytes         <= `EOCB_FIX_BYTES;
         act_out_instance     <= `EOCB_OUT_FIX_BASE;
         act_out_bytes        <= `EOCB_FIX_BYTES;
         act_status_count     <= 4'h0;
         act_control_count    <= 4'h0;
         comm_restart         <= 1'b0;
         nv_commit            <= 1'b0;
      end else begin
         started_q            <= 1'b1;
         // Command reads back as 1 only in the cycle after it is taken
         apply_settings_cmd_q <= apply_go;
         comm_restart         <= apply_go; // R18
         nv_commit            <= apply_go; // R19
         // Switch caught once after reset release, then only on update
         if (!started_q || apply_go) begin
            proto_eip <= protocol_switch; // R22
         end
         if (apply_go) begin
            act_ip_addr    <= {octet_q[0], octet_q[1], octet_q[2], octet_q[3]}; // R4 R17
            act_ip_mask    <= {octet_q[4], octet_q[5], octet_q[6], octet_q[7]}; // R17
            act_ip_gateway <= {octet_q[8], octet_q[9], octet_q[10], octet_q[11]}; // R17
            act_link_speed <= link_speed_select_q; // R17
            act_in_instance  <= in_inst; // R7 R8
            act_in_bytes     <= in_bytes; // R7 R8
            act_out_instance <= out_inst; // R9 R10
            act_out_bytes    <= out_bytes; // R9 R10
            if (input_format_select_q >= `EOCB_FMT_CFG_MIN) begin
               status_param_count_q <= in_cnt; // R13
            end
            if (output_format_select_q >= `EOCB_FMT_CFG_MIN) begin
               control_param_count_q <= out_cnt; // R14
            end
            // Counts steer slot use only under EtherNet/IP
            act_status_count  <= protocol_switch ? in_cnt : 4'h0; // R15 R21
            act_control_count <= protocol_switch ? out_cnt : 4'h0; // R16 R21
         end
      end
   end

   // ----------------------------------------------------------------
   // Live status: version, indicators, negotiated speed
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         module_version_q  <= 16'h0000;
         indicator_state_q <= 4'h0;
         speed_is_100      <= 1'b0;
      end else begin
         module_version_q  <= module_version_in; // R20
         // Bits passed through in indicator_in order; the active protocol is not consulted
         indicator_state_q <= indicator_in; // R1 R2
         case (act_link_speed)
            `EOCB_SPEED_100: speed_is_100 <= 1'b1;
            `EOCB_SPEED_10:  speed_is_100 <= 1'b0;
            default:         speed_is_100 <= phy_link_100; // R6
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         par_rdata   <= 16'h0000;
         par_rvalid  <= 1'b0;
         par_present <= 1'b0;
      end else begin
         par_rvalid  <= par_rd;
         par_present <= 1'b1;
         par_rdata   <= 16'h0000;
         if (in_ip) begin
            par_rdata <= {8'h00, octet_q[ip_idx[3:0]]};
         end else if (in_stat) begin
            par_rdata <= status_address_slots_q[stat_idx[2:0]];
         end else if (in_ctrl) begin
            par_rdata <= control_address_slots_q[ctrl_idx[2:0]];
         end else begin
            case (par_num)
               `EOCB_P_VERSION:   par_rdata <= module_version_q; // R20
               `EOCB_P_INDICATOR: par_rdata <= {12'h000, indicator_state_q}; // R1 R2
               `EOCB_P_SPEED:     par_rdata <= {14'h0000, link_speed_select_q};
               `EOCB_P_IN_FMT:    par_rdata <= {12'h000, input_format_select_q};
               `EOCB_P_OUT_FMT:   par_rdata <= {12'h000, output_format_select_q};
               `EOCB_P_STAT_CNT:  par_rdata <= {12'h000, status_param_count_q}; // R13
               `EOCB_P_CTRL_CNT:  par_rdata <= {12'h000, control_param_count_q}; // R14
               `EOCB_P_APPLY:     par_rdata <= {15'h0000, apply_settings_cmd_q};
               default:           par_rdata <= 16'h0000;
            endcase
         end
         // Format settings hidden outside EtherNet/IP
         if (is_fmt && !proto_eip) begin
            par_present <= 1'b0; // R12
            par_rdata   <= 16'h0000;
         end
      end
   end
endmodule

// ==== logic/eocb_fmt_decode.v ====
// Decodes one cyclic format selector into instance number and data size.
// Assumes a selector already limited to 0..11 by the register bank.
`timescale 1ns/1ps
`include "eocb_consts.vh"
module eocb_fmt_decode #(
   parameter [7:0] FIX_BASE = `EOCB_IN_FIX_BASE,
   parameter [7:0] FIX_ALT  = `EOCB_IN_FIX_ALT,
   parameter [7:0] CFG_BASE = `EOCB_IN_CFG_BASE
) (
   input  wire [3:0] fmt,
   output reg  [7:0] instance_num,
   output reg  [4:0] data_bytes,
   output reg  [3:0] param_num
);
   always @* begin
      if (fmt < `EOCB_FMT_CFG_MIN) begin
         // Fixed instances come in pairs of consecutive numbers
         instance_num = (fmt[1] ? FIX_ALT : FIX_BASE) + {7'h00, fmt[0]};
         data_bytes   = `EOCB_FIX_BYTES;
         param_num    = 4'h0;
      end else begin
         param_num    = fmt - `EOCB_FMT_CFG_BASE;
         // Configurable bases sit four below the first instance, which selector 4 reaches
         instance_num = CFG_BASE + {4'h0, fmt};
         data_bytes   = {param_num, 1'b0};
      end
   end
endmodule

// ==== tb/eocb_bank_asserts.sv ====
// Checker for the configuration bank: parameter port and applied outputs.
// Assumes the bank's own port names; attached by the bind after the module.
`timescale 1ns/1ps
`include "eocb_consts.vh"
module eocb_bank_asserts (
   input wire        clk,
   input wire        rst_n,
   input wire        par_wr,
   input wire        par_rd,
   input wire [6:0]  par_num,
   input wire [15:0] par_wdata,
   input wire [15:0] par_rdata,
   input wire        par_rvalid,
   input wire        par_present,
   input wire [15:0] module_version_in,
   input wire        protocol_switch,
   input wire [3:0]  indicator_in,
   input wire        phy_link_100,
   input wire        proto_eip,
   input wire [31:0] act_ip_addr,
   input wire [1:0]  act_link_speed,
   input wire [7:0]  act_in_instance,
   input wire [4:0]  act_in_bytes,
   input wire [7:0]  act_out_instance,
   input wire [4:0]  act_out_bytes,
   input wire [3:0]  act_status_count,
   input wire [3:0]  act_control_count,
   input wire        comm_restart,
   input wire        nv_commit,
   input wire        speed_is_100
);
   wire apply_w = par_wr && par_num == `EOCB_P_APPLY && par_wdata == `EOCB_APPLY_VAL;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   apply_pulse_a: assert property (apply_w |=> comm_restart && nv_commit)
      else $error("apply did not pulse restart and commit");
   pulse_cause_a: assert property (comm_restart || nv_commit |-> $past(apply_w))
      else $error("pulse without apply");
   pending_hold_a: assert property (!$past(apply_w) |->
      $stable({act_ip_addr, act_link_speed, act_in_instance, act_out_instance, act_status_count, act_control_count}))
      else $error("applied value moved without apply");
   proto_hold_a: assert property ($past(rst_n, 2) && !$past(apply_w) |-> $stable(proto_eip))
      else $error("protocol changed while operating");
   version_read_a: assert property ($past(rst_n) && par_rd && par_num == `EOCB_P_VERSION |=>
      par_rdata == $past(module_version_in, 2))
      else $error("version read wrong");
   indicator_read_a: assert property ($past(rst_n) && par_rd && par_num == `EOCB_P_INDICATOR |=>
      par_rdata == {12'h000, $past(indicator_in, 2)})
      else $error("indicator read wrong");
   read_valid_a: assert property (par_rvalid == $past(par_rd))
      else $error("read valid wrong");
   format_present_a: assert property (par_rd && (par_num == `EOCB_P_IN_FMT || par_num == `EOCB_P_OUT_FMT) |=>
      par_present == $past(proto_eip))
      else $error("format presence wrong");
   link_speed_a: assert property ($past(rst_n) && $stable(act_link_speed) && $stable(phy_link_100) |->
      speed_is_100 == (act_link_speed == `EOCB_SPEED_AUTO ? phy_link_100 : act_link_speed == `EOCB_SPEED_100))
      else $error("link speed wrong");
   in_format_a: assert property (act_in_bytes ==
      (act_in_instance > 8'h88 ? (act_in_instance - 8'h8C) * 2 : 8'h04))
      else $error("input size wrong");
   out_format_a: assert property (act_out_bytes ==
      (act_out_instance > 8'h74 ? (act_out_instance - 8'h78) * 2 : 8'h04))
      else $error("output size wrong");
   modbus_count_a: assert property (apply_w && !protocol_switch |=>
      act_status_count == 4'h0 && act_control_count == 4'h0)
      else $error("counts used in Modbus mode");
endmodule
bind eocb_bank eocb_bank_asserts u_eocb_bank_asserts (.*);

// ==== tb/eocb_keypad.sv ====
// Keypad side model: one write or read per call on the parameter port.
// Assumes the bank takes a request on the rising edge where the strobe is high.
`timescale 1ns/1ps
module eocb_keypad (
   input  wire        clk,
   output reg         par_wr,
   output reg         par_rd,
   output reg  [6:0]  par_num,
   output reg  [15:0] par_wdata,
   input  wire [15:0] par_rdata,
   input  wire        par_present
);
   initial begin
      par_wr = 1'b0;
      par_rd = 1'b0;
      par_num = 7'h00;
      par_wdata = 16'h0000;
   end
   // Idle lines inverted so a stale value never reads as valid
   task put(input [6:0] n, input [15:0] d);
      begin
         @(posedge clk);
         #1;
         par_num = n;
         par_wdata = d;
         par_wr = 1'b1;
         @(posedge clk);
         #1;
         par_wr = 1'b0;
         par_wdata = ~d;
         par_num = ~n;
      end
   endtask
   task get(input [6:0] n, output [15:0] d, output p);
      begin
         @(posedge clk);
         #1;
         par_num = n;
         par_rd = 1'b1;
         @(posedge clk);
         #1;
         par_rd = 1'b0;
         par_num = ~n;
         d = par_rdata;
         p = par_present;
      end
   endtask
endmodule

// ==== tb/test_ethernet_option_config_bank.sv ====
// Testbench for the configuration bank against a behavioural parameter model.
// Assumes the keypad model drives the parameter port; other inputs come from here.
`timescale 1ns/1ps
`include "eocb_consts.vh"
module test_ethernet_option_config_bank;
   reg         clk, rst_n, protocol_switch, phy_link_100, p;
   reg  [15:0] module_version_in, v;
   reg  [3:0]  indicator_in;
   wire        par_wr, par_rd, par_rvalid, par_present, proto_eip, comm_restart, nv_commit, speed_is_100;
   wire [6:0]  par_num;
   wire [15:0] par_wdata, par_rdata;
   wire [31:0] act_ip_addr, act_ip_mask, act_ip_gateway;
   wire [1:0]  act_link_speed;
   wire [7:0]  act_in_instance, act_out_instance;
   wire [4:0]  act_in_bytes, act_out_bytes;
   wire [3:0]  act_status_count, act_control_count;
   integer     fails, checks, i, spd, inf, outf, scnt, ccnt, pro;
   integer     oct [0:11];
   integer     slot [0:15];
   eocb_bank u_eocb_bank (.*);
   eocb_keypad u_eocb_keypad (.*);
   always #12.5 clk = ~clk;
   function [31:0] ipw(input integer k);
      ipw = {oct[k][7:0], oct[k + 1][7:0], oct[k + 2][7:0], oct[k + 3][7:0]};
   endfunction
   function integer inst(input integer f, input integer o);
      inst = f > 3 ? (o ? 117 : 137) + f : (f > 1 ? (o ? 98 : 108) : (o ? 20 : 70)) + f;
   endfunction
   task chk(input string name, input [95:0] exp, input [95:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
         end
      end
   endtask
   task rd(input integer n, input integer e);
      begin
         u_eocb_keypad.get(n[6:0], v, p);
         chk("par_rdata", e, v);
         chk("par_rvalid", 1, par_rvalid);
      end
   endtask
   task act_chk;
      begin
         chk("pulses", 3, {nv_commit, comm_restart});
         chk("ip", {ipw(0), ipw(4), ipw(8)}, {act_ip_addr, act_ip_mask, act_ip_gateway});
         chk("speed", spd, act_link_speed);
         chk("proto", pro, proto_eip);
         chk("insts", (inst(inf, 0) << 8) + inst(outf, 1), {act_in_instance, act_out_instance});
         chk("bytes", inf > 3 ? 2 * inf - 6 : 4, act_in_bytes);
         chk("bytes", outf > 3 ? 2 * outf - 6 : 4, act_out_bytes);
         chk("counts", pro ? (inf > 3 ? inf - 3 : 0) * 16 + (outf > 3 ? outf - 3 : 0) : 0,
             {act_status_count, act_control_count});
      end
   endtask
   task wr(input integer n, input integer d);
      begin
         u_eocb_keypad.put(n[6:0], d[15:0]);
         if (n >= `EOCB_P_IP_FIRST && n <= `EOCB_P_IP_LAST && d < 256) oct[n - 10] = d;
         if (n == `EOCB_P_SPEED && d < 3) spd = d;
         if (n == `EOCB_P_IN_FMT && d < 12 && pro) inf = d;
         if (n == `EOCB_P_OUT_FMT && d < 12 && pro) outf = d;
         if (n >= `EOCB_P_STAT_FIRST && n <= `EOCB_P_CTRL_LAST) slot[n < 51 ? n - 31 : n - 43] = d;
         if (n == `EOCB_P_APPLY && d == 1) begin
            pro = protocol_switch;
            scnt = inf > 3 ? inf - 3 : scnt;
            ccnt = outf > 3 ? outf - 3 : ccnt;
            act_chk;
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      #(25 * 6000);
      fails = fails + 1;
      close_out;
   end
   initial begin
      {clk, rst_n, protocol_switch, phy_link_100} = 4'h3;
      {fails, checks, spd, inf, outf, scnt, ccnt, pro} = 0;
      pro = 1;
      for (i = 0; i < 16; i = i + 1) slot[i] = 0;
      i = $urandom(32'hECC7537E);
      module_version_in = $urandom;
      indicator_in = $urandom;
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      chk("reset insts", 16'h4614, {act_in_instance, act_out_instance});
      for (i = 0; i < 12; i = i + 1) wr(`EOCB_P_IP_FIRST + i, $urandom % 256);
      wr(`EOCB_P_IP_FIRST, 256 + $urandom % 256);
      wr(`EOCB_P_APPLY, 2);
      chk("pending", 0, {act_ip_addr, comm_restart});
      for (i = 0; i < 12; i = i + 1) rd(`EOCB_P_IP_FIRST + i, oct[i]);
      wr(`EOCB_P_APPLY, 1);
      for (i = 0; i < 4; i = i + 1) begin
         phy_link_100 = $urandom;
         wr(`EOCB_P_SPEED, i);
         wr(`EOCB_P_APPLY, 1);
         rd(`EOCB_P_SPEED, spd);
         chk("speed_is_100", spd == 0 ? phy_link_100 : spd == 1, speed_is_100);
      end
      // Last pass returns to a fixed format: counts must keep their old value
      for (i = 0; i < 14; i = i + 1) begin
         wr(`EOCB_P_IN_FMT, i == 13 ? 2 : i);
         wr(`EOCB_P_OUT_FMT, i == 13 ? 2 : i);
         wr(`EOCB_P_APPLY, 1);
         rd(`EOCB_P_STAT_CNT, scnt);
         rd(`EOCB_P_CTRL_CNT, ccnt);
      end
      for (i = 0; i < 16; i = i + 1) wr(i < 8 ? 31 + i : 43 + i, $urandom % 65536);
      for (i = 0; i < 16; i = i + 1) rd(i < 8 ? 31 + i : 43 + i, slot[i]);
      wr(`EOCB_P_STAT_CNT, 1);
      wr(`EOCB_P_CTRL_CNT, 1);
      wr(`EOCB_P_VERSION, 0);
      rd(`EOCB_P_STAT_CNT, scnt);
      rd(`EOCB_P_CTRL_CNT, ccnt);
      for (i = 0; i < 4; i = i + 1) begin
         protocol_switch = i[0];
         indicator_in = $urandom;
         module_version_in = $urandom;
         rd(`EOCB_P_INDICATOR, indicator_in);
         rd(`EOCB_P_VERSION, module_version_in);
         chk("proto_eip", 1, proto_eip);
      end
      protocol_switch = 0;
      wr(`EOCB_P_APPLY, 1);
      wr(`EOCB_P_IN_FMT, 5);
      u_eocb_keypad.get(`EOCB_P_IN_FMT, v, p);
      chk("par_present", 0, p);
      protocol_switch = 1;
      wr(`EOCB_P_APPLY, 1);
      rd(`EOCB_P_IN_FMT, inf);
      chk("par_present", 1, p);
      close_out;
   end
endmodule
